// ==== common/adc_defs.svh ====
`ifndef ADC_DEFS_SVH
`define ADC_DEFS_SVH

// Result and status word widths.
`define ADC_RES_BITS        16
`define ADC_STATUS_BITS     6

// Falling edges that end a chip-select readout, with and without the busy bit.
`define ADC_CS_FALLS        5'd16
`define ADC_CS_BUSY_FALLS   5'd17
`define ADC_CNT_W           5

// Conversion time in ns and the reference clock rate in MHz.
`define ADC_CONV_TIME_NS    300
`define ADC_REF_CLK_MHZ     100
`define ADC_CONV_CYCLES     ((`ADC_CONV_TIME_NS * `ADC_REF_CLK_MHZ + 999) / 1000)

// Reset values.
`define ADC_SDO_RST         1'b0
`define ADC_OE_N_RST        1'b1

`endif

// ==== common/adc_pkg.sv ====
package adc_pkg;

  typedef enum logic {
    MODE_CS,
    MODE_DAISY
  } link_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CONV_CS,
    ST_CONV_DC,
    ST_ACQ_CS,
    ST_CS_RD,
    ST_DC_RD
  } state_t;

  typedef enum logic [1:0] {
    PIN_Z,
    PIN_LOW,
    PIN_DATA
  } sdo_drive_t;

endpackage

// ==== common/conv_if.sv ====
`timescale 1ns/1ns
`default_nettype none

interface conv_if;
  logic start;
  logic busy;
  logic done;

  modport ctrl (
    output start,
    input  busy,
    input  done
  );

  modport timer (
    input  start,
    output busy,
    output done
  );
endinterface

`default_nettype wire

// ==== design/pin_sync.sv ====
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
  parameter int unsigned WIDTH = 3
) (
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // The first stage feeds only the second stage.
  always_comb begin
    meta_d = din;
    sync_d = meta_q;
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign dout = sync_q;

endmodule

`default_nettype wire

// ==== design/conv_timer.sv ====
`timescale 1ns/1ns
`default_nettype none

module conv_timer #(
  parameter int unsigned CONV_CYCLES = 30
) (
  input  wire logic ref_clk,
  input  wire logic resetn,
  conv_if.timer     port
);

  localparam int unsigned CW = $clog2(CONV_CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(CONV_CYCLES - 1);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          busy_q;
  logic          busy_d;
  logic          done_q;
  logic          done_d;

  // A start while busy is ignored; a conversion runs to completion once begun.
  always_comb begin
    cnt_d  = cnt_q;
    busy_d = busy_q;
    done_d = 1'b0;
    if (busy_q) begin
      if (cnt_q == '0) begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end else begin
        cnt_d = cnt_q - CW'(1);
      end
    end else if (port.start) begin
      busy_d = 1'b1;
      cnt_d  = LOAD;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign port.busy = busy_q;
  assign port.done = done_q;

endmodule

`default_nettype wire

// ==== design/adc_serial.sv ====
// Function
// RULE_01: SDI high at convert strobe rise starts conversion in chip-select mode, SDO floats.
// RULE_02: Host holds convert strobe high through conversion and readback in chip-select mode.
// RULE_03: In chip-select mode SDI and convert strobe both low drive SDO low.
// RULE_04: Host lowers SDI before minimum conversion time and holds it for busy indication.
// RULE_05: Conversion ending with SDI low makes SDO switch from floating to driven.
// RULE_06: After busy bit, result shifts out MSB first, one bit per SCK fall.
// RULE_07: Busy readout floats SDO at seventeenth SCK fall or SDI high, first wins.
// RULE_08: SCK low at convert strobe rise starts conversion in daisy-chain mode, no busy.
// RULE_09: Host holds convert strobe high through conversion and readback in daisy-chain mode.
// RULE_10: Daisy-chain puts MSB on SDO at completion, shifts rest on SCK falls.
// RULE_11: Daisy-chain loads SDI into shift register input on each SCK rise.
// RULE_12: Host supplies sixteen clocks per converter to read an N-converter chain.
// RULE_13: Daisy-chain register writes need four wires, data on SDI, strobe low.
// RULE_14: Identical programming of all converters uses eight times N plus one clocks.
// RULE_15: Different contents: farthest first, eight fewer clocks per nearer converter.
// RULE_16: Daisy-chain offers no register readback, only result and optional status bits.
// RULE_17: With status enabled each converter appends six status bits after its result.
// RULE_18: Turbo mode is never in effect during daisy-chain operation.
// RULE_19: Bits received on SDI follow the own result bits out of SDO.
// RULE_20: Host keeps SCK quiet while a conversion is in progress.
`timescale 1ns/1ns
`default_nettype none
`include "adc_defs.svh"

module adc_serial #(
  parameter int unsigned CONV_CYCLES = `ADC_CONV_CYCLES
) (
  input  wire logic                        ref_clk,
  input  wire logic                        resetn,
  input  wire logic                        convert_strobe,
  input  wire logic                        sdi,
  input  wire logic                        sck,
  input  wire logic [`ADC_RES_BITS-1:0]    conv_result,
  input  wire logic [`ADC_STATUS_BITS-1:0] status_word,
  input  wire logic                        status_en,
  input  wire logic                        turbo_en,
  output logic                             sdo,
  output logic                             sdo_oe_n,
  output adc_pkg::link_mode_t              link_mode,
  output logic                             conv_busy,
  output logic                             turbo_active
);
  import adc_pkg::*;

  localparam int unsigned RES  = `ADC_RES_BITS;
  localparam int unsigned STW  = `ADC_STATUS_BITS;
  localparam int unsigned SH_W = RES + STW;
  localparam int unsigned CW   = `ADC_CNT_W;

  // The shift register holds result and status; without status only the low
  // RES bits carry data and the output tap moves down to match.
  function automatic logic [SH_W-1:0] load_word(input logic [RES-1:0] res,
                                                input logic [STW-1:0] st,
                                                input logic           wide);
    load_word = wide ? {res, st} : {{STW{1'b0}}, res};
  endfunction

  function automatic logic tap_bit(input logic [SH_W-1:0] s,
                                   input logic            wide);
    tap_bit = wide ? s[SH_W-1] : s[RES-1];
  endfunction

  // Pins arrive from the host domain and are synchronised before use.
  logic [2:0] pins_s;
  logic       cnv_s;
  logic       sdi_s;
  logic       sck_s;

  pin_sync #(
    .WIDTH (3)
  ) u_sync (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .din     ({convert_strobe, sdi, sck}),
    .dout    (pins_s)
  );

  assign cnv_s = pins_s[2];
  assign sdi_s = pins_s[1];
  assign sck_s = pins_s[0];

  // Previous synchronised levels for edge detection.
  logic [2:0] prev_q;
  logic [2:0] prev_d;
  logic [1:0] settle_q;
  logic [1:0] settle_d;
  logic       cnv_rise;
  logic       sdi_fall;
  logic       sck_rise;
  logic       sck_fall;

  // The synchroniser resets to zero, so SDI reads low until it has flushed.
  // Holding off the low drive for two cycles avoids driving SDO against a high SDI.
  always_comb begin
    prev_d   = pins_s;
    settle_d = {settle_q[0], 1'b1};
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      prev_q   <= '0;
      settle_q <= '0;
    end else begin
      prev_q   <= prev_d;
      settle_q <= settle_d;
    end
  end

  assign cnv_rise = cnv_s & ~prev_q[2];
  assign sdi_fall = ~sdi_s & prev_q[1];
  assign sck_rise = sck_s & ~prev_q[0];
  assign sck_fall = ~sck_s & prev_q[0];

  conv_if cif ();

  conv_timer #(
    .CONV_CYCLES (CONV_CYCLES)
  ) u_timer (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .port    (cif.timer)
  );

  // Readout state.
  state_t          state_q;
  state_t          state_d;
  link_mode_t      mode_q;
  link_mode_t      mode_d;
  logic [SH_W-1:0] sh_q;
  logic [SH_W-1:0] sh_d;
  logic [CW-1:0]   cnt_q;
  logic [CW-1:0]   cnt_d;
  logic [CW-1:0]   end_q;
  logic [CW-1:0]   end_d;
  logic            lead_q;
  logic            lead_d;
  logic            wide_q;
  logic            wide_d;
  logic            din_q;
  logic            din_d;
  logic            sdo_q;
  logic            sdo_d;
  logic            oe_n_q;
  logic            oe_n_d;
  logic            turbo_q;
  logic            turbo_d;
  logic            start;
  sdo_drive_t      drive;
  logic            both_low;

  assign both_low = ~sdi_s & ~cnv_s & settle_q[1]; // RULE_03

  always_comb begin
    state_d = state_q;
    mode_d  = mode_q;
    sh_d    = sh_q;
    cnt_d   = cnt_q;
    end_d   = end_q;
    lead_d  = lead_q;
    wide_d  = wide_q;
    din_d   = din_q;
    start   = 1'b0;
    drive   = PIN_Z;
    case (state_q)
      ST_IDLE, ST_ACQ_CS: begin
        drive = both_low ? PIN_LOW : PIN_Z; // RULE_03
        if (cnv_rise && sdi_s) begin
          start   = 1'b1; // RULE_01
          mode_d  = MODE_CS;
          state_d = ST_CONV_CS;
          drive   = PIN_Z;
        end else if (cnv_rise && !sck_s) begin
          start   = 1'b1; // RULE_08
          mode_d  = MODE_DAISY;
          state_d = ST_CONV_DC;
          drive   = PIN_Z;
        end else if (state_q == ST_ACQ_CS && sdi_fall && cnv_s) begin
          // Reading without busy bit: MSB appears as soon as SDI drops.
          sh_d    = load_word(conv_result, {STW{1'b0}}, 1'b1);
          wide_d  = 1'b1;
          lead_d  = 1'b0;
          cnt_d   = '0;
          end_d   = `ADC_CS_FALLS;
          state_d = ST_CS_RD;
          drive   = PIN_DATA;
        end
      end
      ST_CONV_CS: begin
        // SCK edges are not looked at while converting.
        if (cif.done) begin // RULE_20
          if (!sdi_s) begin
            sh_d    = load_word(conv_result, {STW{1'b0}}, 1'b1);
            wide_d  = 1'b1;
            lead_d  = 1'b1; // RULE_05
            cnt_d   = '0;
            end_d   = `ADC_CS_BUSY_FALLS;
            state_d = ST_CS_RD;
            drive   = PIN_DATA;
          end else begin
            state_d = ST_ACQ_CS;
          end
        end
      end
      ST_CS_RD: begin
        drive = PIN_DATA;
        if (sdi_s) begin
          state_d = ST_IDLE; // RULE_07
          drive   = PIN_Z;
        end else if (sck_fall) begin
          cnt_d = cnt_q + CW'(1);
          if (lead_q) begin
            lead_d = 1'b0; // RULE_06
          end else begin
            sh_d = {sh_q[SH_W-2:0], 1'b0}; // RULE_06
          end
          if (cnt_d == end_q) begin
            state_d = ST_IDLE; // RULE_07
            drive   = PIN_Z;
          end
        end
      end
      ST_CONV_DC: begin
        if (cif.done) begin // RULE_20
          sh_d    = load_word(conv_result, status_word, status_en); // RULE_16 RULE_17
          wide_d  = status_en; // RULE_17
          lead_d  = 1'b0;
          din_d   = 1'b0;
          state_d = ST_DC_RD;
          drive   = PIN_DATA; // RULE_10
        end
      end
      ST_DC_RD: begin
        drive = PIN_DATA;
        if (!cnv_s) begin
          // The frame ends with the strobe; register writes are not decoded here.
          state_d = ST_IDLE;
          drive   = both_low ? PIN_LOW : PIN_Z;
        end else begin
          if (sck_rise) begin
            din_d = sdi_s; // RULE_11
          end
          if (sck_fall) begin
            sh_d = {sh_q[SH_W-2:0], din_q}; // RULE_10 RULE_19
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    case (drive)
      PIN_DATA: begin
        sdo_d  = lead_d ? 1'b0 : tap_bit(sh_d, wide_d);
        oe_n_d = 1'b0;
      end
      PIN_LOW: begin
        sdo_d  = 1'b0;
        oe_n_d = 1'b0;
      end
      default: begin
        sdo_d  = `ADC_SDO_RST;
        oe_n_d = `ADC_OE_N_RST;
      end
    endcase
    turbo_d = turbo_en & (mode_d != MODE_DAISY); // RULE_18
  end

  assign cif.start = start;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      mode_q  <= MODE_CS;
      sh_q    <= '0;
      cnt_q   <= '0;
      end_q   <= '0;
      lead_q  <= 1'b0;
      wide_q  <= 1'b1;
      din_q   <= 1'b0;
      sdo_q   <= `ADC_SDO_RST;
      oe_n_q  <= `ADC_OE_N_RST;
      turbo_q <= 1'b0;
    end else begin
      state_q <= state_d;
      mode_q  <= mode_d;
      sh_q    <= sh_d;
      cnt_q   <= cnt_d;
      end_q   <= end_d;
      lead_q  <= lead_d;
      wide_q  <= wide_d;
      din_q   <= din_d;
      sdo_q   <= sdo_d;
      oe_n_q  <= oe_n_d;
      turbo_q <= turbo_d;
    end
  end

  assign sdo          = sdo_q;
  assign sdo_oe_n     = oe_n_q;
  assign link_mode    = mode_q;
  assign conv_busy    = cif.busy;
  assign turbo_active = turbo_q;

endmodule

`default_nettype wire

// ==== tb/adc_serial_checker.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "adc_defs.svh"

module adc_serial_checker #(
  parameter int unsigned CONV_CYCLES = 30
) (
  input wire logic                     ref_clk,
  input wire logic                     resetn,
  input wire logic                     convert_strobe,
  input wire logic                     sdi,
  input wire logic [`ADC_RES_BITS-1:0] conv_result,
  input wire logic                     sdo,
  input wire logic                     sdo_oe_n,
  input wire logic                     link_mode,
  input wire logic                     conv_busy,
  input wire logic                     turbo_active
);
  import adc_pkg::*;
  logic [7:0] busy_cnt_q;
  logic [7:0] busy_cnt_d;

  always_comb busy_cnt_d = conv_busy ? busy_cnt_q + 8'h01 : 8'h00;
  always_ff @(posedge ref_clk) busy_cnt_q <= resetn ? busy_cnt_d : 8'h00;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  // Six samples cover the two-flop pin synchroniser plus the output register.
  sequence pins_low_s; (!sdi && !convert_strobe)[*6]; endsequence
  sequence sdi_low_s; (!sdi)[*4]; endsequence
  sequence done_s; $fell(conv_busy); endsequence

  a_busy_length: assert property (done_s |-> busy_cnt_q == 8'(CONV_CYCLES))
    else $error("conversion length wrong");
  a_conv_float: assert property (conv_busy |-> sdo_oe_n)
    else $error("sdo driven during conversion");
  a_idle_low: assert property (pins_low_s |-> !sdo_oe_n && !sdo)
    else $error("sdo not driven low");
  a_busy_bit: assert property (sdi_low_s ##0 done_s ##0 link_mode == MODE_CS |-> ##1 (!sdo_oe_n && !sdo))
    else $error("busy bit missing");
  a_daisy_msb: assert property (done_s ##0 link_mode == MODE_DAISY |-> ##1 (!sdo_oe_n && sdo == conv_result[15]))
    else $error("daisy msb missing");
  a_cs_start: assert property ($rose(conv_busy) && $past(sdi, 3) |-> link_mode == MODE_CS)
    else $error("chip-select mode not entered");
  a_daisy_start: assert property ($rose(conv_busy) && !$past(sdi, 3) |-> link_mode == MODE_DAISY)
    else $error("daisy mode not entered");
  a_cs_release: assert property ((link_mode == MODE_CS && sdi)[*5] |-> sdo_oe_n)
    else $error("sdo not released");
  a_no_turbo: assert property ((link_mode == MODE_DAISY)[*2] |-> !turbo_active)
    else $error("turbo active in daisy mode");
endmodule

bind adc_serial adc_serial_checker #(.CONV_CYCLES(CONV_CYCLES)) chk_u (
  .ref_clk(ref_clk), .resetn(resetn), .convert_strobe(convert_strobe), .sdi(sdi),
  .conv_result(conv_result), .sdo(sdo), .sdo_oe_n(sdo_oe_n), .link_mode(link_mode),
  .conv_busy(conv_busy), .turbo_active(turbo_active));

`default_nettype wire

// ==== tb/host_model.sv ====
`timescale 1ns/1ns
`default_nettype none

module host_model (
  input  wire logic ref_clk,
  input  wire logic sdo_line,
  output logic      convert_strobe,
  output logic      sdi,
  output logic      sck
);
  initial begin
    convert_strobe = 1'b0;
    sdi = 1'b1;
    sck = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic pins(input logic s, input logic d);
    convert_strobe <= s;
    sdi <= d;
    tick(6);
  endtask

  // Serial clock stays low outside frames and through the conversion.
  // In chip-select mode without the busy indicator SDI stays high until the conversion is over.
  task automatic start(input logic cs, input logic bi);
    sck <= 1'b0;
    pins(1'b0, cs);
    convert_strobe <= 1'b1;
    tick(4);
    sdi <= cs & !bi;
  endtask

  // Data is sampled late in the high phase; it is valid on both edges.
  task automatic shift(input int n, input logic [31:0] tx, output logic [31:0] rx);
    rx = '0;
    for (int i = 0; i < n; i++) begin
      sdi <= tx[31-i];
      tick(4);
      sck <= 1'b1;
      tick(4);
      rx = {rx[30:0], sdo_line};
      sck <= 1'b0;
    end
    tick(4);
  endtask

  // Register traffic is shifted in with the strobe low, so no conversion starts.
  task automatic write_cfg(input int n, input logic [31:0] tx, output logic [31:0] rx);
    convert_strobe <= 1'b0;
    shift(n, tx, rx);
  endtask
endmodule

`default_nettype wire

// ==== tb/adc_serial_busy_and_daisy_chain_test.sv ====
`timescale 1ns/1ns
`default_nettype none

module adc_serial_busy_and_daisy_chain_test;
  import adc_pkg::*;
  logic        ref_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [15:0] conv_result = 16'h0000;
  logic [5:0]  status_word = 6'h00;
  logic        status_en = 1'b0;
  logic        turbo_en = 1'b0;
  logic        convert_strobe;
  logic        sdi;
  logic        sck;
  logic        sdo;
  logic        sdo_oe_n;
  link_mode_t  link_mode;
  logic        conv_busy;
  logic        turbo_active;
  logic [15:0] lfsr_q = 16'h003c;
  int          n_errors = 0;
  int          tests_run = 0;
  // A pull-up holds the line high while the converter floats it.
  wire         sdo_line = sdo_oe_n ? 1'b1 : sdo;

  always #5 ref_clk = ~ref_clk;

  adc_serial #(.CONV_CYCLES(8)) dut_u (
    .ref_clk(ref_clk), .resetn(resetn), .convert_strobe(convert_strobe), .sdi(sdi), .sck(sck),
    .conv_result(conv_result), .status_word(status_word), .status_en(status_en), .turbo_en(turbo_en),
    .sdo(sdo), .sdo_oe_n(sdo_oe_n), .link_mode(link_mode), .conv_busy(conv_busy),
    .turbo_active(turbo_active));

  host_model host_u (.ref_clk(ref_clk), .sdo_line(sdo_line), .convert_strobe(convert_strobe),
    .sdi(sdi), .sck(sck));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_for(input logic irq);
    int k;
    k = 0;
    while ((irq ? sdo_line : conv_busy) !== 1'b0 && k < 200) begin
      @(posedge ref_clk);
      k++;
    end
    if (k == 200) begin
      n_errors++;
      $display("[ERR] %0t wait timed out", $time);
      final_report();
    end
    repeat (2) @(posedge ref_clk);
  endtask

  // With the strobe low, SDO is driven low exactly while SDI is low; the pull-up shows the rest.
  task automatic write_test(input int n);
    logic [31:0] tx;
    logic [31:0] rx;
    lfsr_q = lfsr(lfsr_q);
    tx = {lfsr_q, lfsr(lfsr_q)};
    host_u.write_cfg(n, tx, rx);
    check(rx, tx >> (32 - n));
    check(conv_busy, 1'b0);
    $display("write test done, clocks %0d", n);
  endtask

  // For chip-select frames bi selects the busy indicator; daisy frames read two converters without status, one result plus status with it.
  task automatic frame(input logic cs, input logic st, input logic bi, input int n);
    logic [31:0] rx;
    logic [31:0] exp;
    logic [15:0] r;
    logic [15:0] x;
    r = lfsr(lfsr_q);
    x = lfsr(r);
    lfsr_q = x;
    conv_result <= r;
    status_word <= x[5:0];
    status_en <= st;
    turbo_en <= x[15];
    host_u.start(cs, bi);
    check(link_mode, cs ? MODE_CS : MODE_DAISY);
    check(sdo_oe_n, 1'b1);
    check(turbo_active, cs & x[15]);
    wait_for(cs & bi);
    check(sdo_oe_n, cs & !bi);
    exp = cs ? {16'h0, r} >> ((bi ? 17 : 16) - n) : st ? {10'h0, r, x[5:0]} : {r, x};
    host_u.shift(n, {x, 16'h0} & {32{!cs}}, rx);
    check(rx, exp);
    if (cs && n == (bi ? 17 : 16)) check(sdo_oe_n, 1'b1);
    host_u.pins(cs, 1'b1);
    check(sdo_oe_n, 1'b1);
    host_u.pins(1'b0, 1'b1);
    $display("frame test done, mode %0d, busy %0d, bits %0d", cs, bi, n);
  endtask

  initial begin
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    host_u.pins(1'b0, 1'b0);
    check(sdo_oe_n, 1'b0);
    check(sdo, 1'b0);
    host_u.pins(1'b0, 1'b1);
    $display("idle test done");
    write_test(24);
    write_test(16);
    frame(1'b1, 1'b0, 1'b1, 17);
    frame(1'b1, 1'b0, 1'b1, 9);
    frame(1'b1, 1'b0, 1'b0, 16);
    frame(1'b0, 1'b0, 1'b0, 32);
    frame(1'b0, 1'b1, 1'b0, 22);
    final_report();
  end
endmodule

`default_nettype wire
